// [rtl/legacy_mode_io_and_interrupt_class.v]
// legacy compatibility mode: port checks, page traps, event classing
// assumes requests come from core logic on the same clock, one per cycle
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`include "legacy_mode_map.vh"
module legacy_mode_io_and_interrupt_class (
    input wire i_core_clk,
    input wire i_arst_n,
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    input wire i_evt_valid,
    input wire [1:0] i_evt_kind,
    input wire [7:0] i_evt_vector,
    input wire i_evt_intr_gate,
    output reg o_evt_done,
    output reg [1:0] o_evt_class,
    output reg [1:0] o_evt_path,
    output reg [7:0] o_evt_vector,
    input wire i_io_valid,
    input wire [15:0] i_io_port,
    output reg o_io_done,
    output reg o_io_fault,
    input wire i_page_valid,
    input wire i_page_present,
    output reg o_page_fault,
    input wire i_sens_valid,
    output reg o_sens_fault,
    output wire o_legacy_mode,
    output wire o_vif_active
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [31:0] flags_q;
    reg [31:0] flags_d;
    reg vme_q;
    reg [1:0] cpl_q;
    reg ack_q;
    reg [1:0] last_class_q;
    reg [1:0] last_path_q;
    reg [31:0] rdata_d;
    reg [1:0] cls_d;
    reg [1:0] path_d;
    reg [7:0] vec_d;
    reg deliver_d;
    reg set_vip_d;

    // ---------------------------------------------------------------
    // combinational terms
    // ---------------------------------------------------------------
    wire [31:0] iomap_word;
    wire [31:0] redir_word;
    wire io_denied;
    wire redirect;
    wire legacy;
    wire virtual_mode_extension_enable;
    wire [1:0] io_privilege_level_field;
    wire [1:0] cur_priv;
    wire wr_take;
    wire rd_first;
    wire sel_flags;
    wire sel_ctrl4;
    wire sel_mode;
    wire sel_redir;
    wire sel_iomap;
    wire sel_status;
    wire io_map_applies;
    wire sens_trap;

    function [31:0] lane_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] be;
        integer k;
        begin
            lane_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // derived mode and privilege
    // ---------------------------------------------------------------
    assign legacy = flags_q[`LM_BIT_LEGACY];
    assign virtual_mode_extension_enable = vme_q & `LM_HAS_EXT;
    assign io_privilege_level_field = flags_q[`LM_BIT_IO_PRIVILEGE_LEVEL_FIELD_HI:`LM_BIT_IO_PRIVILEGE_LEVEL_FIELD_LO];
    // forced user level
    // the written level only counts in protected mode
    assign cur_priv = legacy ? `LM_PRIV_USER : cpl_q;
    assign o_vif_active = virtual_mode_extension_enable & legacy & (io_privilege_level_field != `LM_PRIV_USER);
    assign o_legacy_mode = legacy;
    assign io_map_applies = legacy | (cur_priv > io_privilege_level_field);
    assign sens_trap = cur_priv > io_privilege_level_field;

    // ---------------------------------------------------------------
    // avalon slave: one wait cycle, readdata latched in that cycle
    // ---------------------------------------------------------------
    // the ack flop gives exactly one wait state, so a held request
    // is taken once and the next request waits again
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign wr_take = i_avs_write & ack_q;
    // read data is captured in the wait cycle and stands at the taking edge
    assign rd_first = i_avs_read & ~ack_q;
    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    assign sel_flags = (i_avs_address == `LM_OFF_FLAGS);
    assign sel_ctrl4 = (i_avs_address == `LM_OFF_CTRL4);
    assign sel_mode = (i_avs_address == `LM_OFF_MODE);
    assign sel_redir = (i_avs_address[7:5] == 3'h2) &
        (i_avs_address[1:0] == 2'h0);
    assign sel_iomap = i_avs_address[7] & (i_avs_address[1:0] == 2'h0);
    assign sel_status = (i_avs_address == `LM_OFF_STATUS);

    always @* begin
        rdata_d = 32'h00000000;
        if (sel_flags) begin
            rdata_d = flags_q;
        end else if (sel_ctrl4) begin
            rdata_d[`LM_BIT_VME] = virtual_mode_extension_enable;
        end else if (sel_mode) begin
            rdata_d[1:0] = cur_priv;
        end else if (sel_status) begin
            rdata_d[1:0] = last_class_q;
            rdata_d[3:2] = last_path_q;
            rdata_d[4] = o_vif_active;
            rdata_d[5] = legacy;
        end else if (sel_redir && `LM_HAS_EXT) begin
            rdata_d = redir_word;
        end else if (sel_iomap) begin
            rdata_d = iomap_word;
        end
    end

    // ---------------------------------------------------------------
    // bit maps
    // ---------------------------------------------------------------
    io_perm_map u_iomap (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_wr_en(wr_take & sel_iomap),
        .i_wr_idx(i_avs_address[6:2]),
        .i_wr_data(i_avs_writedata),
        .i_wr_be(i_avs_byteenable),
        .i_rd_idx(i_avs_address[6:2]),
        .o_rd_word(iomap_word),
        .i_port(i_io_port),
        .o_denied(io_denied)
    );

    soft_int_redir_map u_redir (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_wr_en(wr_take & sel_redir),
        .i_wr_idx(i_avs_address[4:2]),
        .i_wr_data(i_avs_writedata),
        .i_wr_be(i_avs_byteenable),
        .i_rd_idx(i_avs_address[4:2]),
        .o_rd_word(redir_word),
        .i_vector(i_evt_vector),
        .o_redirect(redirect)
    );

    // ---------------------------------------------------------------
    // event sorting
    // ---------------------------------------------------------------
    always @* begin
        cls_d = `LM_CLASS_1;
        path_d = `LM_PATH_IDT;
        vec_d = i_evt_vector;
        set_vip_d = 1'b0;
        if (i_evt_kind == `LM_KIND_SOFT) begin
            cls_d = `LM_CLASS_3;
            if (!legacy) begin
                path_d = `LM_PATH_IDT;
            end else if (i_evt_vector == `LM_VEC_BREAK) begin
                path_d = `LM_PATH_IDT;
            end else if (virtual_mode_extension_enable && redirect) begin
                path_d = `LM_PATH_LEGACY;
            end else if (io_privilege_level_field == `LM_PRIV_USER) begin
                path_d = `LM_PATH_IDT;
            end else begin
                path_d = `LM_PATH_GPF;
                vec_d = `LM_VEC_GPF;
            end
        end else if (i_evt_kind == `LM_KIND_MASKABLE && virtual_mode_extension_enable && legacy) begin
            cls_d = `LM_CLASS_2;
            set_vip_d = o_vif_active & ~flags_q[`LM_BIT_VIF];
        end else begin
            cls_d = `LM_CLASS_1;
        end
        // redirected interrupts stay in legacy mode: no flags cleared
        deliver_d = i_evt_valid & legacy & (path_d != `LM_PATH_LEGACY);
    end

    // ---------------------------------------------------------------
    // flags register: software write, then hardware updates win
    // ---------------------------------------------------------------
    always @* begin
        flags_d = flags_q;
        if (wr_take && sel_flags) begin
            flags_d = lane_merge(flags_q, i_avs_writedata,
                i_avs_byteenable) & `LM_FLAGS_MASK;
            if (!`LM_HAS_EXT) begin
                flags_d[`LM_BIT_VIF] = 1'b0;
                flags_d[`LM_BIT_VIP] = 1'b0;
            end
        end
        if (deliver_d) begin
            flags_d[`LM_BIT_LEGACY] = 1'b0;
            flags_d[`LM_BIT_NESTED] = 1'b0;
            flags_d[`LM_BIT_RESUME] = 1'b0;
            flags_d[`LM_BIT_TRAP] = 1'b0;
            if (i_evt_intr_gate) begin
                flags_d[`LM_BIT_INTR_EN] = 1'b0;
            end
        end
        // pending set beats a software clear in the same cycle
        if (i_evt_valid && set_vip_d) begin
            flags_d[`LM_BIT_VIP] = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // register updates
    // ---------------------------------------------------------------
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flags_q <= `LM_FLAGS_RESET;
            vme_q <= 1'b0;
            cpl_q <= 2'h0;
            ack_q <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else begin
            flags_q <= flags_d;
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
            if (rd_first) begin
                o_avs_readdata <= rdata_d;
            end
            if (wr_take && sel_ctrl4 && i_avs_byteenable[0]) begin
                vme_q <= i_avs_writedata[`LM_BIT_VME];
            end
            if (wr_take && sel_mode && i_avs_byteenable[0]) begin
                cpl_q <= i_avs_writedata[1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // answers, one cycle after each request
    // ---------------------------------------------------------------
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_evt_done <= 1'b0;
            o_evt_class <= `LM_CLASS_NONE;
            o_evt_path <= `LM_PATH_IDT;
            o_evt_vector <= 8'h00;
            last_class_q <= `LM_CLASS_NONE;
            last_path_q <= `LM_PATH_IDT;
            o_io_done <= 1'b0;
            o_io_fault <= 1'b0;
            o_page_fault <= 1'b0;
            o_sens_fault <= 1'b0;
        end else begin
            o_evt_done <= i_evt_valid;
            if (i_evt_valid) begin
                o_evt_class <= cls_d;
                o_evt_path <= path_d;
                o_evt_vector <= vec_d;
                last_class_q <= cls_d;
                last_path_q <= path_d;
            end
            o_io_done <= i_io_valid;
            o_io_fault <= i_io_valid & io_denied & io_map_applies;
            o_page_fault <= i_page_valid & ~i_page_present;
            o_sens_fault <= i_sens_valid & sens_trap;
        end
    end
endmodule // legacy_mode_io_and_interrupt_class

// [rtl/legacy_mode_map.vh]
// constants for the legacy compatibility mode checker and event sorter
// assumes one core clock, avalon-mm register access, word aligned offsets
`ifndef LEGACY_MODE_MAP_VH
`define LEGACY_MODE_MAP_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define LM_OFF_FLAGS 8'h00
`define LM_OFF_CTRL4 8'h04
`define LM_OFF_MODE 8'h08
`define LM_OFF_STATUS 8'h0C
`define LM_OFF_REDIR_BASE 8'h40
`define LM_OFF_IOMAP_BASE 8'h80

// -----------------------------------------------------------------
// flags register fields
// -----------------------------------------------------------------
`define LM_FLAGS_MASK 32'h001B7300
`define LM_FLAGS_RESET 32'h00000000
`define LM_BIT_TRAP 8
`define LM_BIT_INTR_EN 9
`define LM_BIT_IO_PRIVILEGE_LEVEL_FIELD_LO 12
`define LM_BIT_IO_PRIVILEGE_LEVEL_FIELD_HI 13
`define LM_BIT_NESTED 14
`define LM_BIT_RESUME 16
`define LM_BIT_LEGACY 17
`define LM_BIT_VIF 19
`define LM_BIT_VIP 20
`define LM_BIT_VME 0

// -----------------------------------------------------------------
// event kinds, classes, paths, vectors
// -----------------------------------------------------------------
`define LM_KIND_EXC 2'h0
`define LM_KIND_HW 2'h1
`define LM_KIND_MASKABLE 2'h2
`define LM_KIND_SOFT 2'h3
`define LM_CLASS_NONE 2'h0
`define LM_CLASS_1 2'h1
`define LM_CLASS_2 2'h2
`define LM_CLASS_3 2'h3
`define LM_PATH_IDT 2'h0
`define LM_PATH_LEGACY 2'h1
`define LM_PATH_GPF 2'h2
`define LM_VEC_BREAK 8'h03
`define LM_VEC_GPF 8'h0D
`define LM_PRIV_USER 2'h3

// -----------------------------------------------------------------
// map sizes and options
// -----------------------------------------------------------------
`define LM_IOMAP_WORDS 32
`define LM_REDIR_WORDS 8
`define LM_HAS_EXT 1'b1

`endif

// [rtl/io_perm_map.v]
// port permission bit map, one bit per port for ports 0 to 1023, set means the access traps
// assumes writes come from the register slave on the same clock
module io_perm_map (
    input wire i_core_clk,
    input wire i_arst_n,
    input wire i_wr_en,
    input wire [4:0] i_wr_idx,
    input wire [31:0] i_wr_data,
    input wire [3:0] i_wr_be,
    input wire [4:0] i_rd_idx,
    output wire [31:0] o_rd_word,
    input wire [15:0] i_port,
    output wire o_denied
);
    wire [31:0] words [0:31];
    genvar g;
    // ---------------------------------------------------------------
    // map words, reset to all trapping
    // ---------------------------------------------------------------
    generate
        for (g = 0; g < 32; g = g + 1) begin : w
            reg [31:0] word_q;
            integer b;
            always @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    word_q <= 32'hFFFFFFFF;
                end else if (i_wr_en && i_wr_idx == g) begin
                    for (b = 0; b < 4; b = b + 1) begin
                        if (i_wr_be[b]) begin
                            word_q[b*8 +: 8] <= i_wr_data[b*8 +: 8];
                        end
                    end
                end
            end
            assign words[g] = word_q;
        end
    endgenerate
    assign o_rd_word = words[i_rd_idx];
    // ports beyond the stored range always trap: the map is kept short
    assign o_denied = (i_port[15:10] != 6'h00) ? 1'b1 :
        words[i_port[9:5]][i_port[4:0]];
endmodule // io_perm_map

// [rtl/soft_int_redir_map.v]
// software interrupt redirection map, 256 flags in 8 words
// assumes writes come from the register slave on the same clock
module soft_int_redir_map (
    input wire i_core_clk,
    input wire i_arst_n,
    input wire i_wr_en,
    input wire [2:0] i_wr_idx,
    input wire [31:0] i_wr_data,
    input wire [3:0] i_wr_be,
    input wire [2:0] i_rd_idx,
    output wire [31:0] o_rd_word,
    input wire [7:0] i_vector,
    output wire o_redirect
);
    wire [31:0] words [0:7];
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : w
            reg [31:0] word_q;
            integer b;
            always @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    word_q <= 32'h00000000;
                end else if (i_wr_en && i_wr_idx == g) begin
                    for (b = 0; b < 4; b = b + 1) begin
                        if (i_wr_be[b]) begin
                            word_q[b*8 +: 8] <= i_wr_data[b*8 +: 8];
                        end
                    end
                end
            end
            assign words[g] = word_q;
        end
    endgenerate
    assign o_rd_word = words[i_rd_idx];
    assign o_redirect = words[i_vector[7:5]][i_vector[4:0]];
endmodule // soft_int_redir_map

// [sim/lm_chk.sv]
// checker on the top ports of the legacy mode block
// assumes one core clock and the active low asynchronous reset
`include "legacy_mode_map.vh"
module lm_chk (
    input wire i_core_clk,
    input wire i_arst_n,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire o_avs_waitrequest,
    input wire i_evt_valid,
    input wire [1:0] i_evt_kind,
    input wire [7:0] i_evt_vector,
    input wire o_evt_done,
    input wire [1:0] o_evt_class,
    input wire [1:0] o_evt_path,
    input wire [7:0] o_evt_vector,
    input wire i_io_valid,
    input wire o_io_done,
    input wire i_page_valid,
    input wire i_page_present,
    input wire o_page_fault,
    input wire o_legacy_mode,
    input wire o_vif_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_wait_one: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("more than one wait state");
    a_evt_done: assert property (i_evt_valid |=> o_evt_done)
        else $error("event not answered");
    a_done_only: assert property (!i_evt_valid |=> !o_evt_done)
        else $error("spurious event done");
    a_io_done: assert property (i_io_valid |=> o_io_done)
        else $error("port check not answered");
    a_page_trap: assert property (
        i_page_valid && !i_page_present |=> o_page_fault)
        else $error("missing page fault");
    a_page_ok: assert property (
        !(i_page_valid && !i_page_present) |=> !o_page_fault)
        else $error("spurious page fault");
    a_soft_class: assert property (
        i_evt_valid && i_evt_kind == `LM_KIND_SOFT
        |=> o_evt_class == `LM_CLASS_3) else $error("soft int not class 3");
    a_exc_class: assert property (
        i_evt_valid && (i_evt_kind == `LM_KIND_EXC ||
        i_evt_kind == `LM_KIND_HW) |=> o_evt_class == `LM_CLASS_1 &&
        o_evt_path == `LM_PATH_IDT) else $error("class 1 misrouted");
    a_break_path: assert property (
        i_evt_valid && i_evt_kind == `LM_KIND_SOFT &&
        i_evt_vector == `LM_VEC_BREAK |=> o_evt_path == `LM_PATH_IDT)
        else $error("breakpoint misrouted");
    a_gpf_vector: assert property (
        o_evt_done && o_evt_path == `LM_PATH_GPF
        |-> o_evt_vector == `LM_VEC_GPF) else $error("gp vector wrong");
    a_mode_clear: assert property (
        o_legacy_mode && i_evt_valid && i_evt_kind == `LM_KIND_EXC
        |=> !o_legacy_mode) else $error("mode kept after delivery");
    a_prot_path: assert property (
        i_evt_valid && !o_legacy_mode |=> o_evt_path == `LM_PATH_IDT)
        else $error("protected event not via table");
    a_virt_legacy: assert property (o_vif_active |-> o_legacy_mode)
        else $error("virtual flags active outside legacy mode");
endmodule // lm_chk

bind legacy_mode_io_and_interrupt_class lm_chk lm_chk_inst (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest), .i_evt_valid(i_evt_valid),
    .i_evt_kind(i_evt_kind), .i_evt_vector(i_evt_vector),
    .o_evt_done(o_evt_done), .o_evt_class(o_evt_class),
    .o_evt_path(o_evt_path), .o_evt_vector(o_evt_vector),
    .i_io_valid(i_io_valid), .o_io_done(o_io_done),
    .i_page_valid(i_page_valid), .i_page_present(i_page_present),
    .o_page_fault(o_page_fault), .o_legacy_mode(o_legacy_mode),
    .o_vif_active(o_vif_active));

// [sim/evt_source.sv]
// interrupt and exception source standing beside the block
// assumes the bench calls fire; one event per call, one cycle pulse
module evt_source (
    input wire i_core_clk,
    output logic o_valid,
    output logic [1:0] o_kind,
    output logic [7:0] o_vector,
    output logic o_gate
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_valid = 1'b0;
        o_kind = 2'h0;
        o_vector = 8'h00;
        o_gate = 1'b0;
    end
    task automatic fire(input logic [1:0] k, input logic [7:0] v,
                        input logic g);
        @(posedge i_core_clk);
        o_valid <= 1'b1;
        o_kind <= k;
        o_vector <= v;
        o_gate <= g;
        @(posedge i_core_clk);
        o_valid <= 1'b0;
        // released vector lines change so stale values never match
        o_vector <= ~v;
    endtask
endmodule // evt_source

// [sim/legacy_mode_io_and_interrupt_class_test.sv]
// self-checking bench for the legacy mode port, page and event logic
// assumes avalon-mm with one wait state and one cycle answers
`include "legacy_mode_map.vh"
module legacy_mode_io_and_interrupt_class_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] LG = 32'h00020000;
    localparam logic [31:0] IO3 = 32'h00003000;
    logic clk = 0, rst_n = 0, rd = 0, wr_s = 0, io_v = 0, pg_v = 0;
    logic pg_p = 0, sn_v = 0, wreq, done, iof, iod, pgf, snf, leg, vact;
    logic gate, ev_v;
    logic [7:0] adr = 8'h00, ev_vec, o_vec;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [3:0] be = 4'hF;
    logic [15:0] port = 16'h0;
    logic [1:0] kind, cls, pth;
    int num_errors = 0, checks = 0;
    always #50 clk = ~clk;
    evt_source evt_source_inst (.i_core_clk(clk), .o_valid(ev_v),
        .o_kind(kind), .o_vector(ev_vec), .o_gate(gate));
    legacy_mode_io_and_interrupt_class legacy_mode_io_and_interrupt_class_inst (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr_s), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_evt_valid(ev_v), .i_evt_kind(kind),
        .i_evt_vector(ev_vec), .i_evt_intr_gate(gate), .o_evt_done(done),
        .o_evt_class(cls), .o_evt_path(pth), .o_evt_vector(o_vec),
        .i_io_valid(io_v), .i_io_port(port), .o_io_done(iod),
        .o_io_fault(iof), .i_page_valid(pg_v), .i_page_present(pg_p),
        .o_page_fault(pgf), .i_sens_valid(sn_v), .o_sens_fault(snf),
        .o_legacy_mode(leg), .o_vif_active(vact));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // waitrequest and readdata are read just after the rising edge,
    // so they hold the values that this edge samples
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        adr <= a;
        wd <= d;
        if (w) wr_s <= 1'b1;
        else rd <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        r = rdat;
        rd <= 1'b0;
        wr_s <= 1'b0;
        wd <= ~d;
        if (n == 20) begin
            check("bus timeout", 1, 0);
            test_done;
        end
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, q);
        check("readdata", q, e);
    endtask
    task automatic io(input logic [15:0] p, input logic e);
        @(posedge clk);
        io_v <= 1'b1;
        port <= p;
        @(posedge clk);
        io_v <= 1'b0;
        #1;
        check("io_done", iod, 1);
        check("io_fault", iof, e);
    endtask
    // sel 0 pulses a page access, sel 1 a sensitive instruction
    task automatic side(input logic sel, input logic p, input logic e);
        @(posedge clk);
        pg_v <= !sel;
        sn_v <= sel;
        pg_p <= p;
        @(posedge clk);
        pg_v <= 1'b0;
        sn_v <= 1'b0;
        #1;
        check("side_fault", sel ? snf : pgf, e);
    endtask
    task automatic ev(input logic [1:0] k, input logic [7:0] v,
                      input logic g, input logic [1:0] c,
                      input logic [1:0] p);
        evt_source_inst.fire(k, v, g);
        #1;
        check("evt_done", done, 1);
        check("evt_class", cls, c);
        check("evt_path", pth, p);
        check("evt_vector", o_vec, p == `LM_PATH_GPF ? `LM_VEC_GPF : v);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rc(`LM_OFF_FLAGS, 0);
        rc(`LM_OFF_CTRL4, 0);
        rc(`LM_OFF_REDIR_BASE + 8'h1C, 0);
        rc(`LM_OFF_IOMAP_BASE, 32'hFFFFFFFF);
        wr(8'h30, 32'h5);
        rc(8'h30, 0);
    endtask
    task automatic t_io;
        wr(`LM_OFF_IOMAP_BASE, 32'hFFFFFFDF);
        wr(`LM_OFF_FLAGS, LG);
        io(16'h0005, 0);
        io(16'h0006, 1);
        io(16'h0400, 1);
        wr(`LM_OFF_FLAGS, LG | IO3);
        io(16'h0006, 1);
        wr(`LM_OFF_FLAGS, 0);
        io(16'h0006, 0);
        wr(`LM_OFF_MODE, 3);
        io(16'h0006, 1);
        wr(`LM_OFF_MODE, 0);
    endtask
    task automatic t_page_sens;
        side(0, 0, 1);
        side(0, 1, 0);
        wr(`LM_OFF_FLAGS, LG);
        rc(`LM_OFF_MODE, 3);
        side(1, 0, 1);
        wr(`LM_OFF_FLAGS, LG | IO3);
        side(1, 0, 0);
    endtask
    task automatic t_class;
        wr(`LM_OFF_FLAGS, LG | IO3 | 32'h00014300);
        ev(`LM_KIND_EXC, 8'h0E, 1, `LM_CLASS_1, `LM_PATH_IDT);
        rc(`LM_OFF_FLAGS, IO3);
        wr(`LM_OFF_FLAGS, LG | 32'h00000200);
        ev(`LM_KIND_HW, 8'h02, 0, `LM_CLASS_1, `LM_PATH_IDT);
        rc(`LM_OFF_FLAGS, 32'h00000200);
        wr(`LM_OFF_FLAGS, LG);
        ev(`LM_KIND_MASKABLE, 8'h20, 0, `LM_CLASS_1, `LM_PATH_IDT);
        wr(`LM_OFF_REDIR_BASE + 8'h04, 32'h00000002);
        wr(`LM_OFF_FLAGS, LG | IO3);
        ev(`LM_KIND_SOFT, 8'h21, 0, `LM_CLASS_3, `LM_PATH_IDT);
        wr(`LM_OFF_FLAGS, LG);
        ev(`LM_KIND_SOFT, 8'h21, 0, `LM_CLASS_3, `LM_PATH_GPF);
        wr(`LM_OFF_FLAGS, LG);
        ev(`LM_KIND_SOFT, 8'h03, 0, `LM_CLASS_3, `LM_PATH_IDT);
    endtask
    task automatic t_ext;
        wr(`LM_OFF_CTRL4, 1);
        rc(`LM_OFF_CTRL4, 1);
        wr(`LM_OFF_FLAGS, LG);
        ev(`LM_KIND_SOFT, 8'h21, 0, `LM_CLASS_3, `LM_PATH_LEGACY);
        check("legacy", leg, 1);
        ev(`LM_KIND_SOFT, 8'h20, 0, `LM_CLASS_3, `LM_PATH_GPF);
        wr(`LM_OFF_FLAGS, LG);
        check("vif_active", vact, 1);
        ev(`LM_KIND_MASKABLE, 8'h20, 0, `LM_CLASS_2, `LM_PATH_IDT);
        bus(1'b0, `LM_OFF_FLAGS, 32'h0, q);
        check("pending", q[`LM_BIT_VIP], 1);
        wr(`LM_OFF_FLAGS, LG | IO3);
        check("vif_active", vact, 0);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_io;
        t_page_sens;
        t_class;
        t_ext;
        test_done;
    end
endmodule // legacy_mode_io_and_interrupt_class_test
